// *** design/instruction_cache_two_way.sv ***
// Controller of the two-way instruction cache: lookup, miss burst, commands.
// Assumes the fetch unit waits for fetch_valid before its next request and
// the instruction bus answers every burst with four acknowledged beats.
`timescale 1ns/1ps
module instruction_cache_two_way (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic                 fetch_req,
  input  wire logic [31:0]          fetch_addr,
  output logic                      fetch_valid,
  output logic [31:0]               fetch_data,
  output logic                      fetch_bus_error,
  output logic                      bus_req,
  output logic [31:0]               bus_addr,
  input  wire logic                 bus_ack,
  input  wire logic [31:0]          bus_data,
  input  wire logic                 bus_error,
  input  wire logic                 bus_no_cache,
  input  wire logic                 spr_wr,
  input  wire logic                 spr_rd,
  input  wire logic [9:0]           spr_num,
  input  wire logic [31:0]          spr_wdata,
  input  wire logic                 user_mode,
  output logic [31:0]               spr_rdata,
  output logic                      spr_done,
  output logic                      spr_prog_exc
);
  import icache_pkg::*;

  array_port_if ap ();

  tag_store u_tags (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ap      (ap.tags)
  );

  line_store u_lines (
    .ref_clk (ref_clk),
    .ap      (ap.lines)
  );

  // ==========================================================================
  // State
  state_t      state;
  logic [31:0] req_addr;
  logic [1:0]  beat;
  logic [31:0] line_buf [WORDS];
  logic        burst_bad;
  logic        no_cache;
  logic        is_lock;
  logic        cache_on;
  logic [2:0]  err;
  logic [31:0] cmd_addr;
  logic [31:0] readback;
  cmd_t        pend_cmd;
  logic        pend_valid;

  // ==========================================================================
  // Register access decode
  logic ours;
  logic priv_ok;
  logic wr_ctrl;
  logic wr_addr;
  logic rd_ctrl;
  cmd_t wr_cmd;
  assign ours    = (spr_wr | spr_rd) &
                   (spr_num == SPR_CTRL | spr_num == SPR_ADDR | spr_num == SPR_READ);
  assign priv_ok = ours & ~user_mode;                        // R8
  assign wr_ctrl = spr_wr & priv_ok & (spr_num == SPR_CTRL);
  assign wr_addr = spr_wr & priv_ok & (spr_num == SPR_ADDR);
  assign rd_ctrl = spr_rd & priv_ok & (spr_num == SPR_CTRL);
  assign wr_cmd  = cmd_t'(spr_wdata[CMD_HI:CMD_LO]);          // R10

  // ==========================================================================
  // Lookup: idle looks at the command address, otherwise the request
  logic [31:0]      look_addr;
  logic [TAG_W-1:0] look_tag;
  logic [WAYS-1:0]  match;
  logic             hit;
  logic             hit_way;
  logic [LINE_W-1:0] hit_line;
  logic [31:0]      hit_word;
  assign look_addr = (state == ST_IDLE) ? cmd_addr : req_addr;
  assign look_tag  = look_addr[31:TAG_LO];                   // R14
  assign ap.idx    = look_addr[TAG_LO-1:IDX_LO];             // R14
  assign match[0]  = ap.rd_valid[0] & (ap.rd_tag[0] == look_tag); // R14
  assign match[1]  = ap.rd_valid[1] & (ap.rd_tag[1] == look_tag); // R14
  assign hit       = |match;
  assign hit_way   = match[1];
  assign hit_line  = ap.rd_line[hit_way];
  assign hit_word  = hit_line[look_addr[IDX_LO-1:WRD_LO]*32 +: 32]; // R2

  // ==========================================================================
  // Victim choice: a lock that hits reuses its hit way; otherwise empty unlocked way, else LRU, never a locked way
  logic free0;
  logic free1;
  logic victim;
  logic victim_ok;
  assign free0     = ~ap.rd_valid[0] & ~ap.rd_lock[0];
  assign free1     = ~ap.rd_valid[1] & ~ap.rd_lock[1];
  assign victim    = (is_lock & hit) ? hit_way :
                     free0 ? 1'b0 :                          // R6
                     free1 ? 1'b1 :                          // R6
                     ap.rd_lock[0] ? 1'b1 :                  // R7
                     ap.rd_lock[1] ? 1'b0 : ap.rd_lru;       // R6
  assign victim_ok = (is_lock & hit) | ~(ap.rd_lock[0] & ap.rd_lock[1]); // R7

  // ==========================================================================
  // Burst buffer word placement, wrapping from the critical word
  logic [1:0]  beat_word;
  logic        alloc_ok;
  assign beat_word = req_addr[IDX_LO-1:WRD_LO] + beat;       // R4
  assign alloc_ok  = (state == ST_WRITE) & cache_on & ~burst_bad & ~no_cache &
                     victim_ok;                              // R17

  // ==========================================================================
  // Array update controls
  logic idle_cmd;
  assign idle_cmd      = (state == ST_IDLE) & pend_valid;
  assign ap.wr_en      = alloc_ok;
  assign ap.wr_way     = victim;                             // R6
  assign ap.wr_tag     = req_addr[31:TAG_LO];
  assign ap.wr_line    = {line_buf[3], line_buf[2], line_buf[1], line_buf[0]};
  assign ap.wr_lock    = is_lock;                            // R7
  assign ap.lru_en     = (state == ST_LOOK) & ~is_lock & cache_on & hit;
  assign ap.lru_val    = ~hit_way;
  assign ap.unlock_en  = idle_cmd & (pend_cmd == CMD_UNLINE) & hit;
  assign ap.unlock_way = hit_way;
  assign ap.unlock_all = idle_cmd & (pend_cmd == CMD_UNALL);
  assign ap.inval_all  = idle_cmd & (pend_cmd == CMD_INVALL); // R15

  // ==========================================================================
  // Error flag events; a set in the clearing cycle survives
  logic [2:0] err_set;
  assign err_set[E_BUS]  = (state == ST_WRITE) & is_lock & burst_bad;
  assign err_set[E_FULL] = (state == ST_LOOK) & is_lock & cache_on & ~victim_ok;
  assign err_set[E_OFF]  = (state == ST_LOOK) & is_lock & ~cache_on;

  // Sticky flags, cleared by a privileged read of the control register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) err <= CTRL_RESET[ERR_HI:ERR_LO];
    else        err <= (err & ~{3{rd_ctrl}}) | err_set;      // R11 R16
  end

  // Address register and pending command
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_addr   <= '0;
      pend_cmd   <= CMD_NONE;
      pend_valid <= 1'b0;
    end else begin
      if (wr_addr) cmd_addr <= spr_wdata;                    // R12
      if (wr_ctrl) begin
        pend_cmd   <= wr_cmd;                                // R10
        pend_valid <= (wr_cmd != CMD_NONE) & (wr_cmd != CMD_RSVD);
      end else if (idle_cmd) begin
        pend_valid <= 1'b0;
      end
    end
  end

  // Enable bit, changed only by commands
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) cache_on <= CTRL_RESET[ON_BIT];
    else if (idle_cmd && pend_cmd == CMD_ENABLE) cache_on <= 1'b1; // R9
    else if (idle_cmd && pend_cmd == CMD_DISABL) cache_on <= 1'b0; // R9
  end

  // Readback of the latest tag lookup
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) readback <= '0;
    else if (state == ST_LOOK || idle_cmd) begin
      readback                 <= '0;                       // R13
      readback[31:TAG_LO]      <= ap.rd_tag[hit_way];
      readback[RB_VALID]       <= ap.rd_valid[hit_way];
      readback[RB_LOCK]        <= ap.rd_lock[hit_way];
      readback[RB_LRU]         <= ap.rd_lru;
    end
  end

  // Register read answer and privilege fault
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      spr_rdata    <= '0;
      spr_done     <= 1'b0;
      spr_prog_exc <= 1'b0;
    end else begin
      spr_done     <= priv_ok;
      spr_prog_exc <= ours & user_mode;                      // R8
      if (spr_rd && priv_ok) begin
        unique case (spr_num)
          SPR_CTRL: spr_rdata <= {cache_on, 9'h000, err, 19'h00000}; // R9 R11
          SPR_ADDR: spr_rdata <= cmd_addr;
          default:  spr_rdata <= readback;                   // R13
        endcase
      end
    end
  end

  // ==========================================================================
  // Fetch and miss sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state           <= ST_IDLE;
      req_addr        <= '0;
      beat            <= '0;
      burst_bad       <= 1'b0;
      no_cache        <= 1'b0;
      is_lock         <= 1'b0;
      bus_req         <= 1'b0;
      bus_addr        <= '0;
      fetch_valid     <= 1'b0;
      fetch_data      <= '0;
      fetch_bus_error <= 1'b0;
    end else begin
      fetch_valid     <= 1'b0;
      fetch_bus_error <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (idle_cmd && pend_cmd == CMD_LOCK) begin
            req_addr <= cmd_addr;                            // R12
            is_lock  <= 1'b1;
            state    <= ST_LOOK;
          end else if (!pend_valid && fetch_req) begin
            req_addr <= fetch_addr;
            is_lock  <= 1'b0;
            state    <= ST_LOOK;
          end
        end
        ST_LOOK: begin
          if (!is_lock && cache_on && hit) begin
            fetch_valid <= 1'b1;                             // R3
            fetch_data  <= hit_word;                         // R3
            state       <= ST_IDLE;
          end else if (is_lock && (!cache_on || !victim_ok)) begin
            state <= ST_IDLE;
          end else begin
            bus_req   <= 1'b1;                               // R4 R17
            bus_addr  <= req_addr;                           // R4
            beat      <= '0;
            burst_bad <= 1'b0;
            state     <= ST_BURST;
          end
        end
        ST_BURST: begin
          if (bus_ack) begin
            line_buf[beat_word] <= bus_data;
            burst_bad           <= burst_bad | bus_error;
            beat                <= beat + 2'h1;
            if (beat == '0) begin
              no_cache <= bus_no_cache;
              if (!is_lock) begin
                fetch_valid     <= 1'b1;                     // R5
                fetch_data      <= bus_data;                 // R5
                fetch_bus_error <= bus_error;
              end
            end
            if (beat == LAST_BEAT) begin
              bus_req <= 1'b0;                               // R4
              state   <= ST_WRITE;
            end
          end
        end
        ST_WRITE: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule : instruction_cache_two_way

// *** design/icache_pkg.sv ***
// Constants, field positions and state codes for the two-way instruction cache.
// Assumes one core clock and big-endian bit numbering mapped onto [31:0].
//
// Functional notes
// R1: 4 KB store: 128 sets, two ways, four 32-bit words per line.
// R2: Lines are aligned on four-word boundaries; low bits pick a word.
// R3: A hit returns the word to the fetch unit with no bus activity.
// R4: A miss runs a four-beat burst at the missed address, requested word first.
// R5: The first burst word goes to the fetch unit without waiting for the line.
// R6: Fill picks an empty way first, else the least recently used way.
// R7: Locked lines keep their contents and are never replaced.
// R8: Registers 560-562; user-level access raises a program exception, nothing changes.
// R9: Control bit 0 shows cache enabled; writes to it are ignored.
// R10: Command field bits 4-6 decodes none, enable, disable, lock, unlocks, invalidate.
// R11: Control bits 10-12 are sticky error flags, set until cleared.
// R12: Address register holds the target for later commands.
// R13: Readback port returns the result of the latest tag array read.
// R14: Set index is address bits 21-27; tag is bits 0-20; hit needs valid.
// R15: Invalidate all clears unlocked lines and points LRU at an unlocked way.
// R16: Hardware sets error flags; software clears them by reading.
// R17: While disabled, fetches go to the bus and nothing is allocated.
package icache_pkg;
  // ==========================================================================
  // Geometry
  localparam int SETS        = 128;
  localparam int WAYS        = 2;
  localparam int WORDS       = 4;
  localparam int IDX_W       = 7;
  localparam int TAG_W       = 21;
  localparam int LINE_W      = 128;
  // Address fields (bit 31 is the most significant)
  localparam int TAG_LO      = 11;
  localparam int IDX_LO      = 4;
  localparam int WRD_LO      = 2;
  // ==========================================================================
  // Register numbers
  localparam logic [9:0] SPR_CTRL = 10'h230;
  localparam logic [9:0] SPR_ADDR = 10'h231;
  localparam logic [9:0] SPR_READ = 10'h232;
  // Control register fields
  localparam int ON_BIT      = 31;
  localparam int CMD_HI      = 27;
  localparam int CMD_LO      = 25;
  localparam int ERR_HI      = 21;
  localparam int ERR_LO      = 19;
  // Readback layout
  localparam int RB_VALID    = 10;
  localparam int RB_LOCK     = 9;
  localparam int RB_LRU      = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // ==========================================================================
  // Commands and states
  typedef enum logic [2:0] {
    CMD_NONE   = 3'b000,
    CMD_ENABLE = 3'b001,
    CMD_DISABL = 3'b010,
    CMD_LOCK   = 3'b011,
    CMD_UNLINE = 3'b100,
    CMD_UNALL  = 3'b101,
    CMD_INVALL = 3'b110,
    CMD_RSVD   = 3'b111
  } cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LOOK  = 2'b01,
    ST_BURST = 2'b10,
    ST_WRITE = 2'b11
  } state_t;

  localparam logic [1:0] LAST_BEAT = 2'h3;
  // Error flag positions within the three-bit group
  localparam int E_BUS   = 2;
  localparam int E_FULL  = 1;
  localparam int E_OFF   = 0;
endpackage : icache_pkg

// *** design/array_port_if.sv ***
// Carries lookups and updates between the controller and the two arrays.
// Assumes all parties run on the same core clock.
`timescale 1ns/1ps
interface array_port_if;
  import icache_pkg::*;
  logic [IDX_W-1:0]             idx;
  logic [WAYS-1:0][TAG_W-1:0]   rd_tag;
  logic [WAYS-1:0][LINE_W-1:0]  rd_line;
  logic [WAYS-1:0]              rd_valid;
  logic [WAYS-1:0]              rd_lock;
  logic                         rd_lru;
  logic                         wr_en;
  logic                         wr_way;
  logic [TAG_W-1:0]             wr_tag;
  logic [LINE_W-1:0]            wr_line;
  logic                         wr_lock;
  logic                         lru_en;
  logic                         lru_val;
  logic                         unlock_en;
  logic                         unlock_way;
  logic                         unlock_all;
  logic                         inval_all;

  modport ctrl  (output idx, wr_en, wr_way, wr_tag, wr_line, wr_lock, lru_en, lru_val,
                 unlock_en, unlock_way, unlock_all, inval_all,
                 input rd_tag, rd_line, rd_valid, rd_lock, rd_lru);
  modport tags  (input idx, wr_en, wr_way, wr_tag, wr_lock, lru_en, lru_val,
                 unlock_en, unlock_way, unlock_all, inval_all,
                 output rd_tag, rd_valid, rd_lock, rd_lru);
  modport lines (input idx, wr_en, wr_way, wr_line, output rd_line);
endinterface : array_port_if

// *** design/tag_store.sv ***
// Tag array with per-set valid, lock and LRU state.
// Assumes the controller issues at most one kind of update per cycle.
`timescale 1ns/1ps
module tag_store (
  input wire logic ref_clk,
  input wire logic rst_n,
  array_port_if.tags ap
);
  import icache_pkg::*;

  logic [TAG_W-1:0] tag_mem [WAYS][SETS];
  logic [WAYS-1:0]  valid   [SETS];
  logic [WAYS-1:0]  lock    [SETS];
  logic             lru     [SETS];

  // ==========================================================================
  // Read side
  assign ap.rd_tag[0] = tag_mem[0][ap.idx];
  assign ap.rd_tag[1] = tag_mem[1][ap.idx];
  assign ap.rd_valid  = valid[ap.idx];
  assign ap.rd_lock   = lock[ap.idx];
  assign ap.rd_lru    = lru[ap.idx];

  // Tag write on fill
  always_ff @(posedge ref_clk) begin
    if (ap.wr_en) tag_mem[ap.wr_way][ap.idx] <= ap.wr_tag;
  end

  // ==========================================================================
  // Per-set state
  for (genvar g = 0; g < SETS; g++) begin : g_set
    logic hit_set;
    assign hit_set = (ap.idx == IDX_W'(g));
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        valid[g] <= '0;
        lock[g]  <= '0;
        lru[g]   <= 1'b0;
      end else if (ap.inval_all) begin
        valid[g] <= valid[g] & lock[g]; // R15
        lru[g]   <= lock[g][0];          // R15
      end else if (ap.unlock_all) begin
        lock[g] <= '0;
      end else if (hit_set) begin
        if (ap.wr_en) begin
          valid[g][ap.wr_way] <= 1'b1;
          lock[g][ap.wr_way]  <= ap.wr_lock; // R7
          lru[g]              <= ~ap.wr_way;
        end else if (ap.lru_en) begin
          lru[g] <= ap.lru_val;
        end else if (ap.unlock_en) begin
          lock[g][ap.unlock_way] <= 1'b0;
        end
      end
    end
  end
endmodule : tag_store

// *** design/line_store.sv ***
// Instruction data array, one whole line per way and set.
// Assumes a line is written in one cycle from the controller's burst buffer.
`timescale 1ns/1ps
module line_store (
  input wire logic ref_clk,
  array_port_if.lines ap
);
  import icache_pkg::*;

  logic [LINE_W-1:0] line_mem [WAYS][SETS];

  // ==========================================================================
  // Read both ways of the addressed set
  assign ap.rd_line[0] = line_mem[0][ap.idx];
  assign ap.rd_line[1] = line_mem[1][ap.idx];

  // Line fill
  always_ff @(posedge ref_clk) begin
    if (ap.wr_en) line_mem[ap.wr_way][ap.idx] <= ap.wr_line; // R1
  end
endmodule : line_store

// *** sim/cache_checker_properties.sv ***
// Port-level assertions for the two-way instruction cache.
// Assumes the fetch unit keeps at most one fetch outstanding.
`timescale 1ns/1ps
module cache_checker (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        fetch_req,
  input wire logic [31:0] fetch_addr,
  input wire logic        fetch_valid,
  input wire logic [31:0] fetch_data,
  input wire logic        fetch_bus_error,
  input wire logic        bus_req,
  input wire logic [31:0] bus_addr,
  input wire logic        bus_ack,
  input wire logic [31:0] bus_data,
  input wire logic        bus_error,
  input wire logic        bus_no_cache,
  input wire logic        spr_wr,
  input wire logic        spr_rd,
  input wire logic [9:0]  spr_num,
  input wire logic [31:0] spr_wdata,
  input wire logic        user_mode,
  input wire logic [31:0] spr_rdata,
  input wire logic        spr_done,
  input wire logic        spr_prog_exc
);
  import icache_pkg::*;
  logic [1:0] ack_cnt;
  logic       fetch_open;
  // Register selection and last burst beat
  wire spr_sel   = (spr_wr || spr_rd) && spr_num >= SPR_CTRL && spr_num <= SPR_READ;
  wire last_beat = bus_req && bus_ack && ack_cnt == 2'd3;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // Beat counter and open-fetch flag
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_cnt    <= 2'd0;
      fetch_open <= 1'b0;
    end else begin
      ack_cnt    <= !bus_req ? 2'd0 : ack_cnt + 2'(bus_ack);
      fetch_open <= fetch_valid ? 1'b0 : (fetch_open || fetch_req);
    end
  end
  // ==========================================================================
  // Properties
  sequence s_first_beat; bus_req && bus_ack && ack_cnt == 2'd0 && fetch_open; endsequence
  sequence s_forward; fetch_valid && fetch_bus_error == $past(bus_error)
    && (fetch_data == $past(bus_data) || $past(bus_error)); endsequence
  property p_forward; s_first_beat |=> s_forward; endproperty
  a_forward: assert property (p_forward) else $error("first beat not forwarded");
  property p_user; spr_sel && user_mode |=> spr_prog_exc && !spr_done; endproperty
  a_user: assert property (p_user) else $error("user access not refused");
  property p_done; spr_sel && !user_mode |=> spr_done && !spr_prog_exc; endproperty
  a_done: assert property (p_done) else $error("privileged access not done");
  property p_hold; !(spr_sel && spr_rd && !user_mode) |=> $stable(spr_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data changed");
  property p_layout; spr_rd && !user_mode && spr_num == SPR_CTRL
    |=> (spr_rdata & 32'h7fc7_ffff) == 32'h0; endproperty
  a_layout: assert property (p_layout) else $error("control reads nonzero field");
  property p_burst_hold; bus_req && !last_beat |=> bus_req; endproperty
  a_burst_hold: assert property (p_burst_hold) else $error("burst dropped early");
  property p_burst_end; last_beat |=> !bus_req ##1 !bus_req; endproperty
  a_burst_end: assert property (p_burst_end) else $error("burst longer than four");
  property p_addr; bus_req && $past(bus_req) |-> $stable(bus_addr) && bus_addr[1:0] == 2'b00;
  endproperty
  a_addr: assert property (p_addr) else $error("burst address moved");
  property p_lookup; fetch_req && !fetch_open && !bus_req |-> ##2 (fetch_valid || bus_req);
  endproperty
  a_lookup: assert property (p_lookup) else $error("lookup gave no answer");
  property p_pulse; fetch_valid |=> !fetch_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("fetch valid too long");
endmodule : cache_checker

bind instruction_cache_two_way cache_checker cache_checker_inst (.ref_clk, .rst_n, .fetch_req,
  .fetch_addr, .fetch_valid, .fetch_data, .fetch_bus_error, .bus_req, .bus_addr, .bus_ack,
  .bus_data, .bus_error, .bus_no_cache, .spr_wr, .spr_rd, .spr_num, .spr_wdata, .user_mode,
  .spr_rdata, .spr_done, .spr_prog_exc);

// *** sim/ibus_model.sv ***
// Instruction bus model: four wrapped beats per burst, optional stall and error.
// Assumes bus_req stays high until the fourth acknowledge is sampled.
`timescale 1ns/1ps
module ibus_model (
  input  wire logic        ref_clk,
  input  wire logic        bus_req,
  input  wire logic [31:0] bus_addr,
  input  wire logic [1:0]  stall,
  input  wire logic [2:0]  err_beat,
  output logic             bus_ack,
  output logic [31:0]      bus_data,
  output logic             bus_error,
  output logic             bus_no_cache
);
  logic [2:0] beat = 3'd0;
  logic [1:0] wcnt = 2'd0;
  initial begin
    bus_ack      = 1'b0;
    bus_data     = 32'h0;
    bus_error    = 1'b0;
    bus_no_cache = 1'b0;
  end
  // ==========================================================================
  // Beats change just after each edge; idle lines toggle
  always @(posedge ref_clk) begin
    #1;
    if (bus_req && beat < 3'd4 && wcnt == stall) begin
      bus_ack   = 1'b1;
      bus_data  = {bus_addr[31:4], bus_addr[3:2] + beat[1:0], 2'b00} ^ 32'h5a5a_5a5a;
      bus_error = (err_beat == beat);
      bus_no_cache = (bus_addr[31:28] == 4'hf);
      beat      = beat + 3'd1;
      wcnt      = 2'd0;
    end else begin
      bus_ack   = 1'b0;
      bus_data  = ~bus_data;
      bus_error = ~bus_error;
      if (bus_req && beat < 3'd4) wcnt = wcnt + 2'd1;
      if (!bus_req) beat = 3'd0;
    end
  end
endmodule : ibus_model

// *** sim/tb_top.sv ***
// Self-checking bench for the two-way instruction cache.
// Assumes the bus model answers every burst with four wrapped beats.
`timescale 1ns/1ps
module tb_top;
  import icache_pkg::*;
  logic        ref_clk = 1'b0, rst_n = 1'b0, fetch_req = 1'b0, spr_wr = 1'b0, spr_rd = 1'b0;
  logic        user_mode = 1'b0, req_d = 1'b0;
  logic        fetch_valid, fetch_bus_error, bus_req, bus_ack, bus_error, bus_no_cache;
  logic        spr_done, spr_prog_exc;
  logic [31:0] fetch_addr = 32'h0, spr_wdata = 32'h0, last_addr = 32'h0;
  logic [31:0] fetch_data, bus_addr, bus_data, spr_rdata;
  logic [9:0]  spr_num = 10'h0;
  logic [1:0]  stall = 2'h0;
  logic [2:0]  err_beat = 3'h7;
  int          n_errors = 0, samples_checked = 0, bursts = 0;
  logic [31:0] row_addr [9] = '{32'h1008, 32'h100c, 32'h1000, 32'h2004, 32'h1004,
                               32'h3000, 32'h2004, 32'h3000, 32'h1000};
  bit          row_miss [9] = '{1, 0, 0, 1, 0, 1, 1, 0, 1};

  instruction_cache_two_way instruction_cache_two_way_inst (.ref_clk, .rst_n, .fetch_req,
    .fetch_addr, .fetch_valid, .fetch_data, .fetch_bus_error, .bus_req, .bus_addr, .bus_ack,
    .bus_data, .bus_error, .bus_no_cache, .spr_wr, .spr_rd, .spr_num, .spr_wdata, .user_mode,
    .spr_rdata, .spr_done, .spr_prog_exc);
  ibus_model ibus_model_inst (.ref_clk, .bus_req, .bus_addr, .stall, .err_beat, .bus_ack,
    .bus_data, .bus_error, .bus_no_cache);

  // ==========================================================================
  // Clock and burst monitor
  initial forever #10 ref_clk = ~ref_clk;
  always @(negedge ref_clk) begin
    if (bus_req === 1'b1 && !req_d) begin
      bursts++;
      last_addr = bus_addr;
    end
    req_d = (bus_req === 1'b1);
  end
  // ==========================================================================
  // Shared tasks
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic check(input bit ok, input string m);
    samples_checked++;
    if (!ok) begin
      n_errors++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask : check
  task automatic finish_test;
    $display("Comparisons %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic wait_for(input bit low_req);
    int i;
    for (i = 0; i < 60; i++) begin
      if (low_req ? bus_req === 1'b0 : fetch_valid === 1'b1) break;
      tick();
    end
    if (i == 60) begin
      n_errors++;
      $display("Error at %0t: wait ran out", $time);
      finish_test();
    end
  endtask : wait_for
  task automatic spr(input bit wr, input logic [9:0] num, input logic [31:0] wd, input bit usr);
    spr_wr    = wr;
    spr_rd    = !wr;
    spr_num   = num;
    spr_wdata = wd;
    user_mode = usr;
    tick();
    spr_wr = 1'b0;
    spr_rd = 1'b0;
    check(spr_done === !usr && spr_prog_exc === usr, "access answer");
    tick();
    user_mode = 1'b0;
  endtask : spr
  task automatic rd_ctrl(input logic [31:0] exp);
    spr(1'b0, SPR_CTRL, 32'h0, 1'b0);
    check(spr_rdata === exp, "control value");
  endtask : rd_ctrl
  task automatic fetch(input logic [31:0] a, input bit miss);
    int b0;
    b0 = bursts;
    fetch_addr = a;
    fetch_req  = 1'b1;
    tick();
    fetch_req = 1'b0;
    wait_for(1'b0);
    check({fetch_bus_error, fetch_data} === {miss && err_beat == 0, a ^ 32'h5a5a_5a5a}, "word");
    wait_for(1'b1);
    tick();
    tick();
    check((bursts - b0) == int'(miss), "burst count");
    if (miss) check(last_addr === a, "burst address");
  endtask : fetch
  task automatic cmd(input logic [2:0] code, input int exp);
    int b0;
    b0 = bursts;
    spr(1'b1, SPR_CTRL, {4'h0, code, 25'h0}, 1'b0);
    repeat (4) tick();
    wait_for(1'b1);
    tick();
    tick();
    check((bursts - b0) == exp, "command burst count");
  endtask : cmd
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    rd_ctrl(32'h0);
    spr(1'b1, SPR_CTRL, 32'h8000_0000, 1'b0);
    rd_ctrl(32'h0);
    fetch(32'h1000, 1'b1);
    fetch(32'h1000, 1'b1);
    cmd(3'b001, 0);
    rd_ctrl(32'h8000_0000);
    for (int i = 0; i < 9; i++) begin
      stall = 2'(i % 3);
      fetch(row_addr[i], row_miss[i]);
    end
    spr(1'b1, SPR_CTRL, 32'h0400_0000, 1'b1);
    spr(1'b0, SPR_READ, 32'h0, 1'b1);
    rd_ctrl(32'h8000_0000);
    spr(1'b1, SPR_ADDR, 32'h3000, 1'b0);
    cmd(3'b100, 0);
    spr(1'b0, SPR_READ, 32'h0, 1'b0);
    check(spr_rdata[31:9] === {21'd6, 2'b10}, "readback tag");
    spr(1'b1, SPR_ADDR, 32'h1000, 1'b0);
    cmd(3'b011, 1);
    rd_ctrl(32'h8000_0000);
    fetch(32'h5000, 1'b1);
    fetch(32'h6000, 1'b1);
    fetch(32'h1000, 1'b0);
    cmd(3'b110, 0);
    fetch(32'h1000, 1'b0);
    fetch(32'h6000, 1'b1);
    spr(1'b1, SPR_ADDR, 32'h5000, 1'b0);
    cmd(3'b011, 1);
    spr(1'b1, SPR_ADDR, 32'h6000, 1'b0);
    cmd(3'b011, 0);
    rd_ctrl(32'h8010_0000);
    rd_ctrl(32'h8000_0000);
    fetch(32'h9000, 1'b1);
    fetch(32'h9000, 1'b1);
    cmd(3'b101, 0);
    cmd(3'b110, 0);
    fetch(32'h1000, 1'b1);
    spr(1'b1, SPR_ADDR, 32'h7000, 1'b0);
    err_beat = 3'd2;
    cmd(3'b011, 1);
    err_beat = 3'd7;
    rd_ctrl(32'h8020_0000);
    fetch(32'h7000, 1'b1);
    err_beat = 3'd1;
    fetch(32'h8000, 1'b1);
    err_beat = 3'd0;
    fetch(32'h8004, 1'b1);
    err_beat = 3'd7;
    fetch(32'h8000, 1'b1);
    repeat (2) fetch(32'hf000_0000, 1'b1);
    cmd(3'b111, 0);
    rd_ctrl(32'h8000_0000);
    cmd(3'b010, 0);
    rd_ctrl(32'h0);
    cmd(3'b011, 0);
    rd_ctrl(32'h0008_0000);
    rd_ctrl(32'h0);
    finish_test();
  end
endmodule : tb_top
